// File: hpc_top.sv
`timescale 1ns/1ps
// hibernation power control: battery check, slow clock, backed store, pin hold
module hpc_top
  import hpc_pkg::*;
#(
  parameter int WORDS = 16,
  parameter int CHECK_TICKS = 64,
  parameter int PINS = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic [1:0] hresp,
  input wire logic slow_clk_pin,
  input wire logic fast_xtal_pin,
  input wire logic battery_low_pin,
  input wire logic wake_pin,
  input wire logic [PINS-1:0] pinctl_out,
  input wire logic [PINS-1:0] pinctl_oe,
  output logic [PINS-1:0] pad_out,
  output logic [PINS-1:0] pad_oe,
  output logic pinctl_reset,
  output logic regulator_on,
  output logic osc_power_on,
  output logic crystal_strong_drive,
  output logic battery_measure_on,
  output logic irq
);
  localparam int AW = $clog2(WORDS);
  localparam int CW = $clog2(CHECK_TICKS + 1);

  // address phase capture
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  wire take = hsel && hready && (htrans == HPC_HTRANS_NONSEQ);
  wire wr_now = wr_pend_q;
  // decode of the registered write address
  wire w_ctl = wr_now && addr_q == HPC_CTL_OFS;
  wire w_clk = wr_now && addr_q == HPC_CLK_OFS;
  wire w_bat = wr_now && addr_q == HPC_BAT_OFS;
  wire w_ris = wr_now && addr_q == HPC_RIS_OFS;
  wire w_im = wr_now && addr_q == HPC_IM_OFS;
  wire w_req = wr_now && addr_q == HPC_REQ_OFS;
  wire w_mem = wr_now && addr_q >= HPC_MEM_OFS && addr_q < HPC_MEM_OFS + 8'(WORDS * 4);
  wire rd_mem_addr = haddr[7:0] >= HPC_MEM_OFS && haddr[7:0] < HPC_MEM_OFS + 8'(WORDS * 4);

  // configuration registers
  logic en_q;
  logic hold_q;
  logic div_sel_q;
  logic osc_off_q;
  logic strong_q;
  logic detect_q;
  logic cancel_q;
  logic lowbat_q;
  logic im_q;
  hpc_state_e st_q;

  // two-flop synchronisers for all pin inputs
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end
    else
    begin
      s1_q <= {wake_pin, battery_low_pin, fast_xtal_pin, slow_clk_pin};
      s2_q <= s1_q;
    end
  end
  logic [3:0] s3_q; // edge history, reads second stage only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s3_q <= 4'h0;
    else
      s3_q <= s2_q;
  end
  wire slow_rise = s2_q[0] && !s3_q[0];
  wire fast_rise = s2_q[1] && !s3_q[1];
  wire bat_low_s = s2_q[2];
  wire wake_rise = s2_q[3] && !s3_q[3];

  // divide-by-128 prescaler of the fast crystal
  logic [6:0] div_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_q <= 7'h00;
    else if (fast_rise)
      div_q <= div_q + 7'h01;
  end
  wire div_tick = fast_rise && div_q == 7'(HPC_FAST_DIV - 1);
  // time base selection; nothing ticks while the module is off
  wire tick = en_q && (div_sel_q ? div_tick : slow_rise);

  // battery measurement and periodic interval
  logic meas_q;
  logic [2:0] mcnt_q;
  logic [CW-1:0] icnt_q;
  wire force_go = w_bat && hwdata[HPC_BAT_FORCE_BIT] && en_q;
  wire per_go = tick && icnt_q == CW'(CHECK_TICKS - 1) && detect_q;
  wire meas_done = meas_q && tick && mcnt_q == 3'(HPC_MEAS_TICKS - 1);
  // a measurement launched at this very edge must also hold off sleep
  wire meas_start = force_go || (per_go && !meas_q);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meas_q <= 1'b0;
      mcnt_q <= 3'h0;
      icnt_q <= '0;
    end
    else
    begin
      // interval counter restarts on a forced check
      if (force_go || (tick && icnt_q == CW'(CHECK_TICKS - 1)))
        icnt_q <= '0;
      else if (tick)
        icnt_q <= icnt_q + CW'(1);
      if (meas_start)
      begin
        meas_q <= 1'b1;
        mcnt_q <= 3'h0;
      end
      else if (meas_done || !en_q)
        meas_q <= 1'b0;
      else if (meas_q && tick)
        mcnt_q <= mcnt_q + 3'h1;
    end
  end
  wire lowbat_set = meas_done && bat_low_s;

  // sticky low-battery status, set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      lowbat_q <= 1'b0;
    else if (lowbat_set)
      lowbat_q <= 1'b1;
    else if (w_ris && hwdata[HPC_RIS_LOWBAT_BIT])
      lowbat_q <= 1'b0;
  end

  // hibernation sequencer
  logic req_q;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q <= HPC_AWAKE;
      req_q <= 1'b0;
    end
    else
    begin
      req_q <= w_req && en_q;
      case (st_q)
        HPC_AWAKE:
          if (req_q)
            st_q <= HPC_WAIT_MEAS;
        HPC_WAIT_MEAS:
          // held off while a measurement runs or is just starting
          if (!meas_q && !meas_start)
            st_q <= (cancel_q && (lowbat_q || bat_low_s)) ? HPC_AWAKE : HPC_ASLEEP;
        HPC_ASLEEP:
          if (wake_rise || !en_q)
            st_q <= HPC_AWAKE;
        default:
          st_q <= HPC_AWAKE;
      endcase
    end
  end
  wire asleep = st_q == HPC_ASLEEP;

  // configuration writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_q <= 1'b0;
      hold_q <= 1'b0;
      div_sel_q <= 1'b0;
      osc_off_q <= 1'b0;
      strong_q <= 1'b0;
      detect_q <= 1'b0;
      cancel_q <= 1'b0;
      im_q <= 1'b0;
    end
    else
    begin
      if (w_ctl)
      begin
        en_q <= hwdata[HPC_CTL_EN_BIT];
        hold_q <= hwdata[HPC_CTL_HOLD_BIT] && hwdata[HPC_CTL_EN_BIT];
      end
      if (w_clk)
      begin
        div_sel_q <= hwdata[HPC_CLK_DIV_BIT];
        osc_off_q <= hwdata[HPC_CLK_OFF_BIT];
        strong_q <= hwdata[HPC_CLK_STRONG_BIT];
      end
      if (w_bat)
      begin
        detect_q <= hwdata[HPC_BAT_DETECT_BIT];
        cancel_q <= hwdata[HPC_BAT_CANCEL_BIT];
      end
      if (w_im)
        im_q <= hwdata[HPC_RIS_LOWBAT_BIT];
    end
  end

  // pin hold latch: captures controller levels when hold is armed
  logic [PINS-1:0] held_out_q;
  logic [PINS-1:0] held_oe_q;
  logic woke_held_q; // set once asleep with hold armed
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      held_out_q <= '0;
      held_oe_q <= '0;
    end
    else if (!hold_q || (st_q == HPC_AWAKE && !woke_held_q && !req_q && !w_req))
    begin
      // track while awake; frozen from a request until the hold is released or a cancelled request returns to awake
      held_out_q <= pinctl_out;
      held_oe_q <= pinctl_oe;
    end
  end
  // after wake the held copy still governs until released
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      woke_held_q <= 1'b0;
    else if (!hold_q)
      woke_held_q <= 1'b0;
    else if (asleep)
      woke_held_q <= 1'b1;
  end
  wire use_held = hold_q && (asleep || woke_held_q);

  // pad outputs registered; controller gated off during hibernation
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pad_out <= '0;
      pad_oe <= '0;
      pinctl_reset <= 1'b0;
      regulator_on <= 1'b1;
      osc_power_on <= 1'b1;
      crystal_strong_drive <= 1'b0;
      battery_measure_on <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      pinctl_reset <= asleep;
      pad_out <= use_held ? held_out_q : (asleep ? '0 : pinctl_out);
      pad_oe <= use_held ? held_oe_q : (asleep ? '0 : pinctl_oe);
      regulator_on <= !asleep;
      osc_power_on <= en_q && !osc_off_q;
      crystal_strong_drive <= strong_q;
      battery_measure_on <= meas_q;
      irq <= lowbat_q && im_q && en_q;
    end
  end

  // backed word store
  logic [31:0] mem_rd;
  hpc_store #(.DEPTH(WORDS), .WIDTH(32)) u_store (
    .hclk(hclk),
    .wr_en(w_mem && en_q),
    .wr_idx(AW'((addr_q - HPC_MEM_OFS) >> 2)),
    .wr_data(hwdata),
    .rd_idx(AW'((haddr[7:0] - HPC_MEM_OFS) >> 2)),
    .rd_data(mem_rd)
  );

  // register read mux for the address phase
  logic [31:0] rmux;
  logic rd_mem_q;
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (haddr[7:0])
      HPC_CTL_OFS: rmux = {30'h0, hold_q, en_q};
      HPC_CLK_OFS: rmux = {29'h0, strong_q, osc_off_q, div_sel_q};
      HPC_BAT_OFS: rmux = {29'h0, cancel_q, detect_q, 1'b0};
      HPC_RIS_OFS: rmux = {31'h0, lowbat_q};
      HPC_IM_OFS: rmux = {31'h0, im_q};
      HPC_STS_OFS: rmux = {30'h0, asleep, meas_q};
      default: rmux = 32'h0000_0000; // unmapped reads zero
    endcase
  end

  // bus pipeline: zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      rd_mem_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      rd_mem_q <= take && !hwrite && rd_mem_addr;
      if (take)
      begin
        addr_q <= haddr[7:0];
        rdata_q <= rmux;
      end
    end
  end
  // store reads return through its own output register
  assign hrdata = rd_mem_q ? mem_rd : rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = HPC_HRESP_OKAY;
endmodule

// File: hpc_pkg.sv
// package: register map, field positions and timing constants of the hibernation control block
package hpc_pkg;
  // register byte offsets (word aligned)
  localparam logic [7:0] HPC_CTL_OFS = 8'h00;
  localparam logic [7:0] HPC_CLK_OFS = 8'h04;
  localparam logic [7:0] HPC_BAT_OFS = 8'h08;
  localparam logic [7:0] HPC_RIS_OFS = 8'h0C;
  localparam logic [7:0] HPC_IM_OFS = 8'h10;
  localparam logic [7:0] HPC_REQ_OFS = 8'h14;
  localparam logic [7:0] HPC_STS_OFS = 8'h18;
  localparam logic [7:0] HPC_MEM_OFS = 8'h40;
  // control register fields
  localparam int HPC_CTL_EN_BIT = 0;
  localparam int HPC_CTL_HOLD_BIT = 1;
  // clock register fields
  localparam int HPC_CLK_DIV_BIT = 0;
  localparam int HPC_CLK_OFF_BIT = 1;
  localparam int HPC_CLK_STRONG_BIT = 2;
  // battery register fields
  localparam int HPC_BAT_FORCE_BIT = 0;
  localparam int HPC_BAT_DETECT_BIT = 1;
  localparam int HPC_BAT_CANCEL_BIT = 2;
  // status bits
  localparam int HPC_RIS_LOWBAT_BIT = 0;
  localparam int HPC_STS_PEND_BIT = 0;
  localparam int HPC_STS_ASLEEP_BIT = 1;
  // slow clock derivation: divided crystal ratio
  localparam int HPC_FAST_DIV = 128;
  // battery measurement duration in slow ticks
  localparam int HPC_MEAS_TICKS = 4;
  // htrans and hresp encodings
  localparam logic [1:0] HPC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HPC_HRESP_OKAY = 2'h0;
  // hibernation sequencer states
  typedef enum logic [1:0] {HPC_AWAKE, HPC_WAIT_MEAS, HPC_ASLEEP} hpc_state_e;
endpackage

// File: hpc_store.sv
`timescale 1ns/1ps
// battery-backed word store with registered read data
module hpc_store
  import hpc_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int WIDTH = 32
)
(
  input wire logic hclk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  // no reset: contents survive processor power-off and core resets
  logic [WIDTH-1:0] mem_q [DEPTH];

  // write port and registered read port
  always_ff @(posedge hclk)
  begin
    if (wr_en)
    begin
      mem_q[wr_idx] <= wr_data;
    end
    rd_data <= mem_q[rd_idx];
  end
endmodule

// File: hpc_checker.sv
`timescale 1ns/1ps
// port checker of the hibernation control block
module hpc_checker
  import hpc_pkg::*;
#(
  parameter int PINS = 8
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic [1:0] hresp,
  input wire logic [PINS-1:0] pad_out,
  input wire logic [PINS-1:0] pad_oe,
  input wire logic pinctl_reset,
  input wire logic regulator_on,
  input wire logic crystal_strong_drive,
  input wire logic battery_measure_on,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // address phase accepted at this edge
  wire logic taken = hsel && hready && htrans == HPC_HTRANS_NONSEQ;
  logic rd_gap_q; // data phase of a read from a hole
  logic rd_bat_q; // data phase of a battery register read
  logic wr_clk_q; // data phase of a clock register write
  // remember what the last accepted request was
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_gap_q <= 1'h0;
      rd_bat_q <= 1'h0;
      wr_clk_q <= 1'h0;
    end
    else
    begin
      rd_gap_q <= taken && !hwrite && haddr[7:0] == 8'h20;
      rd_bat_q <= taken && !hwrite && haddr[7:0] == HPC_BAT_OFS;
      wr_clk_q <= taken && hwrite && haddr[7:0] == HPC_CLK_OFS;
    end
  end
  a_ready_okay: assert property (hreadyout && hresp == HPC_HRESP_OKAY)
    else $error("slave not ready or not okay");
  a_gap_reads_zero: assert property (rd_gap_q |-> hrdata == 32'h0)
    else $error("hole read not zero");
  a_force_reads_zero: assert property (rd_bat_q |-> !hrdata[HPC_BAT_FORCE_BIT])
    else $error("force bit reads back set");
  a_drive_follows: assert property (wr_clk_q |-> ##2
    crystal_strong_drive == $past(hwdata[HPC_CLK_STRONG_BIT], 2))
    else $error("drive strength not taken");
  a_sleep_resets_pins: assert property (pinctl_reset == !regulator_on)
    else $error("pin controller reset out of step");
  a_sleep_pads_hold: assert property ((!regulator_on)[*3] |->
    $stable(pad_out) && $stable(pad_oe))
    else $error("pads moved while asleep");
  a_sleep_after_meas: assert property ($fell(regulator_on) |-> !battery_measure_on)
    else $error("slept during measurement");
  a_measure_span: assert property ($rose(battery_measure_on) |-> battery_measure_on[*6])
    else $error("measurement too short");
  c_sleep: cover property ($fell(regulator_on));
  c_irq: cover property ($rose(irq));
  c_meas: cover property ($rose(battery_measure_on));
endmodule
bind hpc_top hpc_checker #(.PINS(PINS)) u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .pad_out, .pad_oe,
  .pinctl_reset, .regulator_on, .crystal_strong_drive, .battery_measure_on, .irq);

// File: hpc_supply.sv
`timescale 1ns/1ps
// model of the battery, the two crystals and the external regulator
module hpc_supply
(
  input wire logic osc_power_on,
  input wire logic regulator_on,
  input wire logic low_req,
  output logic slow_clk_pin,
  output logic fast_xtal_pin,
  output logic battery_low_pin,
  output logic vdd_ok
);
  // both crystals start at rest
  initial
  begin
    slow_clk_pin = 1'h0;
    fast_xtal_pin = 1'h0;
  end
  // slow crystal, 100 ns; stands low once its oscillator is off
  always #50 slow_clk_pin = osc_power_on & ~slow_clk_pin;
  // fast crystal, 20 ns; also needs the oscillator
  always #10 fast_xtal_pin = osc_power_on & ~fast_xtal_pin;
  // comparator: high means the cell is low
  assign battery_low_pin = low_req;
  // processor rail exists only while the regulator runs
  assign vdd_ok = regulator_on;
endmodule

// File: test_hibernation_power_control.sv
`timescale 1ns/1ps
// self-checking bench of the hibernation control block
module test_hibernation_power_control
  import hpc_pkg::*;
;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic wake_pin = 1'h0;
  logic low_req = 1'h0;
  logic [7:0] pinctl_out = 8'h00;
  logic [7:0] pinctl_oe = 8'h00;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic hreadyout, pinctl_reset, regulator_on, osc_power_on, crystal_strong_drive;
  logic battery_measure_on, irq, slow_clk_pin, fast_xtal_pin, battery_low_pin, vdd_ok;
  wire logic hready = hreadyout; // single slave drives the bus ready
  int failures = 0;
  int comparisons = 0;
  logic [31:0] q; // last read word
  int n; // cycle count of the last wait
  always #2.5 hclk = ~hclk;
  hpc_top #(.WORDS(16), .CHECK_TICKS(8), .PINS(8)) dut (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .slow_clk_pin, .fast_xtal_pin, .battery_low_pin, .wake_pin, .pinctl_out, .pinctl_oe,
    .pad_out, .pad_oe, .pinctl_reset, .regulator_on, .osc_power_on, .crystal_strong_drive,
    .battery_measure_on, .irq);
  hpc_supply far (.osc_power_on, .regulator_on, .low_req, .slow_clk_pin, .fast_xtal_pin,
    .battery_low_pin, .vdd_ok);
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single bus transfer; read data lands in q
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= HPC_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'h1) @(posedge hclk);
    q = hrdata;
  endtask
  // measurement must start within 8 cycles, then n counts its length
  task wait_meas;
    n = 0;
    while (battery_measure_on !== 1'h1 && n < 8)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(battery_measure_on), 32'h1);
    n = 0;
    while (battery_measure_on === 1'h1)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
  // backed words read back
  task read_store;
    for (int i = 0; i < 16; i++)
    begin
      xfer(1'h0, HPC_MEM_OFS + 8'(4 * i), 32'h0);
      chk(q, {16'hC0DE, 16'(i)});
    end
  endtask
  // module off: nothing may act
  task t_disabled;
    xfer(1'h1, HPC_CTL_OFS, 32'h2);
    xfer(1'h0, HPC_CTL_OFS, 32'h0);
    chk(q, 32'h0);
    xfer(1'h1, HPC_BAT_OFS, 32'h1);
    xfer(1'h1, HPC_REQ_OFS, 32'h1);
    repeat (8) @(posedge hclk);
    chk({battery_measure_on, regulator_on, osc_power_on}, 32'h2);
  endtask
  // enable, fill the store, probe a hole
  task t_store;
    xfer(1'h1, HPC_CTL_OFS, 32'h1);
    for (int i = 0; i < 16; i++)
      xfer(1'h1, HPC_MEM_OFS + 8'(4 * i), {16'hC0DE, 16'(i)});
    read_store;
    xfer(1'h0, 8'h20, 32'h0);
    chk(q, 32'h0);
  endtask
  // both clock sources, pending flag, oscillator and drive bits
  task t_clock;
    xfer(1'h1, HPC_CLK_OFS, 32'h1);
    xfer(1'h1, HPC_BAT_OFS, 32'h1);
    xfer(1'h0, HPC_STS_OFS, 32'h0);
    chk(32'(q[HPC_STS_PEND_BIT]), 32'h1);
    wait_meas;
    chk(32'(n > 1400 && n < 2200), 32'h1);
    xfer(1'h0, HPC_STS_OFS, 32'h0);
    chk(32'(q[HPC_STS_PEND_BIT]), 32'h0);
    xfer(1'h1, HPC_CLK_OFS, 32'h0);
    xfer(1'h1, HPC_BAT_OFS, 32'h1);
    wait_meas;
    chk(32'(n > 50 && n < 110), 32'h1);
    xfer(1'h1, HPC_CLK_OFS, 32'h6);
    repeat (2) @(posedge hclk);
    chk({osc_power_on, crystal_strong_drive}, 32'h1);
    xfer(1'h1, HPC_CLK_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    chk({osc_power_on, crystal_strong_drive}, 32'h2);
  endtask
  // low cell: flag, interrupt, and the request is cancelled
  task t_lowbat;
    low_req <= 1'h1;
    xfer(1'h1, HPC_IM_OFS, 32'h1);
    xfer(1'h1, HPC_BAT_OFS, 32'h5);
    xfer(1'h1, HPC_REQ_OFS, 32'h1);
    wait_meas;
    repeat (20) @(posedge hclk);
    chk(32'(vdd_ok), 32'h1);
    chk(32'(irq), 32'h1);
    xfer(1'h0, HPC_RIS_OFS, 32'h0);
    chk(32'(q[HPC_RIS_LOWBAT_BIT]), 32'h1);
    low_req <= 1'h0;
    xfer(1'h1, HPC_RIS_OFS, 32'h1);
    xfer(1'h1, HPC_BAT_OFS, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  // sleep with pin hold, wake, release the hold
  task t_sleep;
    pinctl_out <= 8'hA5;
    pinctl_oe <= 8'hFF;
    xfer(1'h1, HPC_CTL_OFS, 32'h3);
    xfer(1'h0, HPC_CTL_OFS, 32'h0);
    chk(q, 32'h3);
    xfer(1'h1, HPC_BAT_OFS, 32'h1);
    xfer(1'h1, HPC_REQ_OFS, 32'h1);
    repeat (4) @(posedge hclk);
    chk(32'(vdd_ok), 32'h1);
    wait_meas;
    n = 0;
    while (regulator_on === 1'h1 && n < 20)
    begin
      @(posedge hclk);
      n++;
    end
    chk({vdd_ok, pinctl_reset}, 32'h1);
    pinctl_out <= 8'h3C; // controller reconfigured before release
    repeat (4) @(posedge hclk);
    chk({pad_oe, pad_out}, 32'hFFA5);
    wake_pin <= 1'h1;
    repeat (10) @(posedge hclk);
    wake_pin <= 1'h0;
    n = 0;
    while (regulator_on !== 1'h1 && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    chk({vdd_ok, pad_out}, 32'h1A5);
    read_store;
    chk({pad_oe, pad_out}, 32'hFFA5);
    xfer(1'h1, HPC_CTL_OFS, 32'h1);
    repeat (3) @(posedge hclk);
    chk({pad_oe, pad_out}, 32'hFF3C);
    xfer(1'h0, HPC_CTL_OFS, 32'h0);
    chk(q, 32'h1);
  endtask
  // periodic check starts by itself, then shut the module down
  task t_periodic;
    xfer(1'h1, HPC_BAT_OFS, 32'h2);
    n = 0;
    while (battery_measure_on !== 1'h1 && n < 400)
    begin
      @(posedge hclk);
      n++;
    end
    chk(32'(battery_measure_on), 32'h1);
    xfer(1'h1, HPC_CTL_OFS, 32'h0);
    repeat (2) @(posedge hclk);
    chk(32'(osc_power_on), 32'h0);
  endtask
  // verdict and end of run
  task close_out;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    t_disabled;
    t_store;
    t_clock;
    t_lowbat;
    t_sleep;
    t_periodic;
    close_out;
  end
  // the run needs about 12 us; eight times that means a hang
  initial
  begin
    #100us;
    failures++;
    close_out;
  end
endmodule
